// ---- rtl/hsc_conditioning.sv ----
// Hall signal-conditioning datapath with its AHB-Lite registers.
// Assumes the Hall and temperature converters deliver samples on
// this clock, and the output DAC takes a code on each strobe.
module hsc_conditioning
	import hsc_pkg::*;
#(
	parameter int HALL_W    = 16,
	parameter int TEMP_W    = 16,
	parameter int LPF_DIVN  = LPF_DIV,
	parameter int OUT_DIVN  = OUT_DIV,
	parameter int HALL_SH   = 4,
	parameter int INTERP_SH = 2
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	input  wire logic                     hallValid,
	input  wire logic signed [HALL_W-1:0] hallData,
	input  wire logic                     tempValid,
	input  wire logic signed [TEMP_W-1:0] tempData,
	output logic [1:0]                    adcRange,
	output logic [11:0]                   dacCode,
	output logic                          dacStrobe
);

	// ----------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------
	hsc_cfg_t             cfg_reg;
	logic                 wrPend_reg;
	logic [7:0]           wrAddr_reg;
	logic                 addrPhase;
	logic [31:0]          readMux;
	logic [12:0]          lpfCnt_reg;
	logic [9:0]           outCnt_reg;
	logic                 lpfTick_reg;
	logic                 outTick_reg;
	logic signed [HALL_W-1:0] hallLatch_reg;
	logic signed [TEMP_W-1:0] tempLatch_reg;
	logic signed [HALL_W-1:0] filtSample;
	logic                 filtValid;
	logic [3:0]           stageValid_reg;
	logic signed [16:0]   tempDiff_reg;
	logic signed [HALL_W-1:0] sampleS1_reg;
	logic signed [17:0]   linTerm_reg;
	logic signed [17:0]   sqTerm_reg;
	logic signed [HALL_W-1:0] sampleS2_reg;
	logic signed [19:0]   effGain_reg;
	logic signed [21:0]   offsetSum_reg;
	logic [11:0]          target_reg;
	logic signed [33:0]   linProd;
	logic signed [33:0]   sqProd;
	logic signed [34:0]   quadProd;
	logic signed [17:0]   quadTerm;
	logic signed [15:0]   gainBase;
	logic signed [15:0]   offsetBase;
	logic signed [HALL_W+19:0] gainProd;
	logic signed [21:0]   scaled;
	logic signed [12:0]   interpStep;

	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	// Half-span in mT; undefined code 2 reads as the mid span.
	function automatic logic [7:0] rangeSpan(input logic [1:0] r);
		case (r)
			RANGE_50:  rangeSpan = SPAN_50;
			RANGE_200: rangeSpan = SPAN_200;
			default:   rangeSpan = SPAN_100;
		endcase
	endfunction : rangeSpan

	function automatic logic [11:0] limit12(input logic signed [21:0] v);
		if (v < 22'sd0) begin
			limit12 = 12'h000;
		end else if (v > $signed({10'h000, DAC_MAX})) begin
			limit12 = DAC_MAX;
		end else begin
			limit12 = v[11:0];
		end
	endfunction : limit12

	// ----------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------
	// Zero wait states: reads are sampled in the address phase, so
	// hrdata stands in the data phase right after it.
	assign addrPhase = hsel & htrans[1] & hready;

	always_comb begin
		readMux = 32'h0000_0000;
		case (haddr[7:0])
			CTRL_OFS: begin
				readMux[CTRL_RANGE_LSB +: 2] = cfg_reg.inputRange;
				readMux[CTRL_LP_LSB +: 3] = cfg_reg.lowpassSetting;
			end
			GAIN_OFS:   readMux[14:0] = cfg_reg.gainCode;
			OFFS_OFS:   readMux[14:0] = cfg_reg.offsetCode;
			TZERO_OFS:  readMux[15:0] = cfg_reg.tempZeroPoint;
			TCLIN_OFS:  readMux[15:0] = cfg_reg.linearTempCoeff;
			TCQUAD_OFS: readMux[15:0] = cfg_reg.quadraticTempCoeff;
			STAT_OFS: begin
				readMux[STAT_DAC_LSB +: 12] = dacCode;
				readMux[STAT_SPAN_LSB +: 8] =
					rangeSpan(cfg_reg.inputRange);
			end
			EGAIN_OFS:  readMux = 32'(effGain_reg);
			default:    readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addrPhase && !hwrite) begin
				hrdata <= readMux;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
		end else begin
			wrPend_reg <= addrPhase & hwrite;
			if (addrPhase) begin
				wrAddr_reg <= haddr[7:0];
			end
		end
	end

	// Writes land at the end of the data phase; other offsets,
	// including the read-only ones, ignore the data.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_reg <= '{RANGE_RST, LP_RST, GAIN_RST, OFFS_RST, TZERO_RST,
				TC_RST, TC_RST};
		end else if (wrPend_reg) begin
			case (wrAddr_reg)
				CTRL_OFS: begin
					cfg_reg.inputRange <=
						hwdata[CTRL_RANGE_LSB +: 2];
					cfg_reg.lowpassSetting <=
						hwdata[CTRL_LP_LSB +: 3];
				end
				GAIN_OFS:   cfg_reg.gainCode <= hwdata[14:0];
				OFFS_OFS:   cfg_reg.offsetCode <= hwdata[14:0];
				TZERO_OFS:  cfg_reg.tempZeroPoint <= hwdata[15:0];
				TCLIN_OFS:  cfg_reg.linearTempCoeff <= hwdata[15:0];
				TCQUAD_OFS: begin
					cfg_reg.quadraticTempCoeff <= hwdata[15:0];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------
	// Converter range and sample capture
	// ----------------------------------------------------------
	// The range code goes straight to the Hall converter; no
	// lockout keeps software from changing it after calibration.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			adcRange <= RANGE_RST;
		end else begin
			adcRange <= cfg_reg.inputRange;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hallLatch_reg <= '0;
			tempLatch_reg <= '0;
		end else begin
			if (hallValid) begin
				hallLatch_reg <= hallData;
			end
			if (tempValid) begin
				tempLatch_reg <= tempData;
			end
		end
	end

	// ----------------------------------------------------------
	// Rate dividers
	// ----------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lpfCnt_reg  <= 13'h0000;
			lpfTick_reg <= 1'b0;
		end else if (lpfCnt_reg == 13'(LPF_DIVN - 1)) begin
			lpfCnt_reg  <= 13'h0000;
			lpfTick_reg <= 1'b1;
		end else begin
			lpfCnt_reg  <= lpfCnt_reg + 13'h0001;
			lpfTick_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			outCnt_reg  <= 10'h000;
			outTick_reg <= 1'b0;
		end else if (outCnt_reg == 10'(OUT_DIVN - 1)) begin
			outCnt_reg  <= 10'h000;
			outTick_reg <= 1'b1;
		end else begin
			outCnt_reg  <= outCnt_reg + 10'h001;
			outTick_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// Input low-pass
	// ----------------------------------------------------------
	hsc_lowpass #(
		.W    (HALL_W),
		.FRAC (8)
	) u_lowpass (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.tick      (lpfTick_reg),
		.setting   (cfg_reg.lowpassSetting),
		.sampleIn  (hallLatch_reg),
		.filtOut   (filtSample),
		.filtValid (filtValid)
	);

	// ----------------------------------------------------------
	// Temperature compensation and gain pipeline
	// ----------------------------------------------------------
	// The coefficients carry 12 fraction bits like the gain, and
	// the square is pre-scaled by 2^16 to keep the product narrow.
	assign linProd  = tempDiff_reg * cfg_reg.linearTempCoeff;
	assign sqProd   = tempDiff_reg * tempDiff_reg;
	assign quadProd = $signed({1'b0, sqTerm_reg})
	                * cfg_reg.quadraticTempCoeff;
	assign quadTerm = quadProd[29:12];
	assign gainBase = $signed({1'b0, cfg_reg.gainCode})
	                - $signed({1'b0, CODE_ZERO});
	assign offsetBase = $signed({1'b0, cfg_reg.offsetCode})
	                  - $signed({1'b0, CODE_ZERO});
	assign gainProd = sampleS2_reg * effGain_reg;
	assign scaled   = 22'(gainProd >>> (GAIN_FRAC + HALL_SH));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stageValid_reg <= 4'h0;
		end else begin
			stageValid_reg <= {stageValid_reg[2:0], filtValid};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tempDiff_reg <= '0;
			sampleS1_reg <= '0;
		end else if (filtValid) begin
			tempDiff_reg <= 17'(tempLatch_reg)
			              - 17'(cfg_reg.tempZeroPoint);
			sampleS1_reg <= filtSample;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			linTerm_reg  <= '0;
			sqTerm_reg   <= '0;
			sampleS2_reg <= '0;
		end else if (stageValid_reg[0]) begin
			linTerm_reg  <= linProd[29:12];
			sqTerm_reg   <= sqProd[33:16];
			sampleS2_reg <= sampleS1_reg;
		end
	end

	// Coefficients are read live; a write mid-sample mixes old and
	// new terms for one 16 kHz update only.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			effGain_reg  <= '0;
		end else if (stageValid_reg[1]) begin
			effGain_reg  <= 20'(gainBase) + 20'(linTerm_reg)
			              + 20'(quadTerm);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			offsetSum_reg <= '0;
		end else if (stageValid_reg[2]) begin
			offsetSum_reg <= scaled + 22'(offsetBase);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			target_reg <= 12'h000;
		end else if (stageValid_reg[3]) begin
			target_reg <= limit12(offsetSum_reg);
		end
	end

	// ----------------------------------------------------------
	// Output interpolation
	// ----------------------------------------------------------
	// Always on: with the input filter bypassed this one-pole
	// smoother is what bounds the output bandwidth.
	assign interpStep = ($signed({1'b0, target_reg})
	                  - $signed({1'b0, dacCode})) >>> INTERP_SH;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dacCode     <= 12'h000;
			dacStrobe   <= 1'b0;
		end else begin
			dacStrobe <= outTick_reg;
			if (outTick_reg) begin
				if (interpStep == 13'sd0) begin
					dacCode <= target_reg;
				end else begin
					dacCode <= 12'(13'(dacCode) + interpStep);
				end
			end
		end
	end

endmodule : hsc_conditioning

// ---- rtl/hsc_pkg.sv ----
// Constants, register map and carrier types of the Hall
// signal-conditioning path.
// Assumes one 125 MHz clock and 32-bit AHB-Lite data.
package hsc_pkg;

	// ----------------------------------------------------------
	// Clock and update rates
	// ----------------------------------------------------------
	localparam int CLK_HZ      = 125000000;
	localparam int LPF_RATE_HZ = 16000;
	localparam int OUT_RATE_HZ = 256000;
	localparam int LPF_DIV     = CLK_HZ / LPF_RATE_HZ;
	localparam int OUT_DIV     = CLK_HZ / OUT_RATE_HZ;

	// ----------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] GAIN_OFS   = 8'h04;
	localparam logic [7:0] OFFS_OFS   = 8'h08;
	localparam logic [7:0] TZERO_OFS  = 8'h0c;
	localparam logic [7:0] TCLIN_OFS  = 8'h10;
	localparam logic [7:0] TCQUAD_OFS = 8'h14;
	localparam logic [7:0] STAT_OFS   = 8'h18;
	localparam logic [7:0] EGAIN_OFS  = 8'h1c;

	// ----------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------
	localparam int CTRL_RANGE_LSB = 0;
	localparam int CTRL_LP_LSB    = 2;
	localparam int STAT_DAC_LSB   = 0;
	localparam int STAT_SPAN_LSB  = 16;

	// ----------------------------------------------------------
	// Codes and reset values
	// ----------------------------------------------------------
	localparam logic [1:0]  RANGE_50   = 2'h3;
	localparam logic [1:0]  RANGE_100  = 2'h1;
	localparam logic [1:0]  RANGE_200  = 2'h0;
	localparam logic [7:0]  SPAN_50    = 8'h32;
	localparam logic [7:0]  SPAN_100   = 8'h64;
	localparam logic [7:0]  SPAN_200   = 8'hc8;
	localparam logic [2:0]  LP_BYPASS  = 3'h7;
	localparam logic [14:0] CODE_ZERO  = 15'h4000;
	localparam int          GAIN_FRAC  = 12;
	localparam logic [11:0] DAC_MAX    = 12'hfff;
	localparam logic [1:0]  RANGE_RST  = RANGE_100;
	localparam logic [2:0]  LP_RST     = 3'h1;
	localparam logic [14:0] GAIN_RST   = 15'h5000;
	localparam logic [14:0] OFFS_RST   = 15'h4800;
	localparam logic [15:0] TZERO_RST  = 16'h0000;
	localparam logic [15:0] TC_RST     = 16'h0000;

	// ----------------------------------------------------------
	// Configuration carrier
	// ----------------------------------------------------------
	typedef struct packed {
		logic [1:0]         inputRange;
		logic [2:0]         lowpassSetting;
		logic [14:0]        gainCode;
		logic [14:0]        offsetCode;
		logic signed [15:0] tempZeroPoint;
		logic signed [15:0] linearTempCoeff;
		logic signed [15:0] quadraticTempCoeff;
	} hsc_cfg_t;

endpackage : hsc_pkg

// ---- rtl/hsc_lowpass.sv ----
// First-order digital low-pass on the Hall sample stream.
// Assumes a one-cycle update enable from the owner's divider.
module hsc_lowpass
	import hsc_pkg::*;
#(
	parameter int W    = 16,
	parameter int FRAC = 8
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                tick,
	input  wire logic [2:0]          setting,
	input  wire logic signed [W-1:0] sampleIn,
	output logic signed [W-1:0]      filtOut,
	output logic                     filtValid
);

	// ----------------------------------------------------------
	// Accumulator
	// ----------------------------------------------------------
	// Extra fraction bits keep the slow settings from stalling more
	// than one LSB short of the input, so the DC error stays within one LSB.
	localparam int AW = W + FRAC + 1;

	logic signed [AW-1:0] acc_reg;
	logic signed [AW-1:0] target;
	logic signed [AW-1:0] step;
	logic [2:0]           shiftAmt;

	// Sign bit repeated so negative samples stay negative
	assign target = {sampleIn[W-1], sampleIn, {FRAC{1'b0}}};
	assign shiftAmt = 3'h7 - setting;
	assign step = (target - acc_reg) >>> shiftAmt;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_reg <= '0;
		end else if (tick) begin
			if (setting == LP_BYPASS) begin
				acc_reg <= target;
			end else begin
				acc_reg <= acc_reg + step;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			filtOut   <= '0;
			filtValid <= 1'b0;
		end else begin
			filtValid <= tick;
			if (tick) begin
				filtOut <= (setting == LP_BYPASS) ? sampleIn
				         : acc_reg[FRAC+W-1:FRAC];
			end
		end
	end

endmodule : hsc_lowpass

// ---- verif/hsc_conditioning_chk.sv ----
// Port-level timing checks of the Hall conditioning path.
// Assumes one clock, hready tied to hreadyout, bound from the bench.
module hsc_conditioning_chk
	import hsc_pkg::*;
#(
	parameter int OUT_DIVN = OUT_DIV
) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic [1:0]  adcRange,
	input wire logic [11:0] dacCode,
	input wire logic        dacStrobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic rdTaken;
	logic seenStrobe;
	int   gapCnt;
	assign rdTaken = hsel && htrans[1] && hready && !hwrite;

	// Strobe phase is free after reset, so spacing is judged from the 2nd
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gapCnt     <= 0;
			seenStrobe <= 1'b0;
		end else begin
			gapCnt     <= dacStrobe ? 0 : gapCnt + 1;
			seenStrobe <= seenStrobe | dacStrobe;
		end
	end

	sequence s_ctrl_wr_addr;
		hsel && htrans[1] && hready && hwrite && haddr[7:0] == CTRL_OFS;
	endsequence
	sequence s_stat_rd;
		rdTaken && haddr[7:0] == STAT_OFS;
	endsequence

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	a_zero_wait: assert property (hreadyout == 1'b1)
		else $error("hreadyout low");
	a_dac_holds: assert property (!$stable(dacCode) |-> dacStrobe)
		else $error("dacCode moved without strobe");
	a_strobe_period: assert property (seenStrobe |->
		(dacStrobe == (gapCnt == OUT_DIVN - 1)))
		else $error("dacStrobe spacing wrong");
	a_range_follows: assert property (s_ctrl_wr_addr ##1 1'b1 |->
		##2 adcRange == $past(hwdata[1:0], 2))
		else $error("adcRange does not follow range code");
	a_stat_dac_read: assert property (s_stat_rd |=>
		hrdata[11:0] == $past(dacCode) && hrdata[31:24] == 8'h00)
		else $error("status read wrong dac code");
	a_unmapped_zero: assert property (rdTaken && haddr[7:0] > 8'h1c
		|=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_hrdata_stands: assert property (!$stable(hrdata) |-> $past(rdTaken))
		else $error("hrdata changed without read");
	a_reset_release: assert property ($fell(sys_rst) |->
		dacCode == 12'h000 && !dacStrobe && adcRange == RANGE_RST)
		else $error("outputs not cleared at reset release");
endmodule : hsc_conditioning_chk

// ---- verif/hsc_adc_model.sv ----
// Hall and temperature converter stand-in plus DAC latch.
// Assumes the bench sets analog levels and the sample pace.
module hsc_adc_model (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               slowMode,
	input  wire logic signed [15:0] hallLevel,
	input  wire logic signed [15:0] tempLevel,
	input  wire logic [11:0]        dacCode,
	input  wire logic               dacStrobe,
	output logic                    hallValid,
	output logic signed [15:0]      hallData,
	output logic                    tempValid,
	output logic signed [15:0]      tempData,
	output logic [11:0]             dacHeld
);
	timeunit 1ns;
	timeprecision 1ps;
	int paceCnt;
	// Lines show inverted junk between samples so stale data is not reused
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			paceCnt   <= 0;
			hallValid <= 1'b0;
			tempValid <= 1'b0;
			hallData  <= 16'h0000;
			tempData  <= 16'h0000;
		end else begin
			paceCnt   <= (paceCnt >= (slowMode ? 6 : 1)) ? 0 : paceCnt + 1;
			hallValid <= (paceCnt == 0);
			tempValid <= (paceCnt == 0);
			hallData  <= (paceCnt == 0) ? hallLevel : ~hallData;
			tempData  <= (paceCnt == 0) ? tempLevel : ~tempData;
		end
	end
	always_ff @(posedge clk) begin
		if (dacStrobe) begin
			dacHeld <= dacCode;
		end
	end
endmodule : hsc_adc_model

// ---- verif/tb_hsc_conditioning.sv ----
// Self-checking bench of the Hall conditioning path.
// Assumes hsc_adc_model as converter partner; checker bound below.
module tb_hsc_conditioning
	import hsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LPF_N = 16;
	localparam int OUT_N = 4;
	logic               clk, sys_rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0]        haddr, hwdata, hrdata, d;
	logic [1:0]         htrans, adcRange;
	logic [2:0]         hsize;
	logic               hallValid, tempValid, dacStrobe, slowMode;
	logic signed [15:0] hallData, tempData, hallLevel, tempLevel;
	logic [11:0]        dacCode, dacHeld;
	logic [15:0]        lfsrState = 16'h2573;
	int                 errCount = 0, cmpCount = 0;
	int                 e, g, o, h, t, tz, c1, c2;
	logic [7:0]  ra[7] = '{CTRL_OFS, GAIN_OFS, OFFS_OFS, TZERO_OFS,
		TCLIN_OFS, TCQUAD_OFS, EGAIN_OFS};
	// Effective gain reads zero until the first filter update
	logic [31:0] rv[7] = '{32'h5, 32'h5000, 32'h4800, 32'h0, 32'h0, 32'h0,
		32'h0};
	logic [31:0] rm[6] = '{32'h1f, 32'h7fff, 32'h7fff, 32'hffff, 32'hffff,
		32'hffff};
	logic [1:0]  rc[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
	logic [7:0]  sp[4] = '{SPAN_50, SPAN_100, SPAN_200, SPAN_100};
	int cg[5] = '{32'h5000, 32'h5000, 32'h7fff, 32'h0, 32'h3000};
	int co[5] = '{32'h4800, 32'h4fff, 32'h4800, 32'h4800, 32'h4000};
	int ch[5] = '{32'h0, 32'h0, 32'h7fff, 32'h7fff, -32'h3e80};

	hsc_conditioning #(.LPF_DIVN(LPF_N), .OUT_DIVN(OUT_N)) hsc_conditioning_i (
		.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .hallValid,
		.hallData, .tempValid, .tempData, .adcRange, .dacCode, .dacStrobe);
	hsc_adc_model hsc_adc_model_i (.clk, .sys_rst, .slowMode, .hallLevel,
		.tempLevel, .dacCode, .dacStrobe, .hallValid, .hallData, .tempValid,
		.tempData, .dacHeld);

	always #4 clk = ~clk;

	// ----------------------------------------------------------
	// Reference model and bus tasks
	// ----------------------------------------------------------
	function automatic logic [15:0] rnd();
		lfsrState = {lfsrState[14:0], ^(lfsrState & 16'hb400)};
		return lfsrState;
	endfunction : rnd
	function automatic int target(int gc, int oc, int hv);
		int s;
		s = ((hv * (gc - 16384)) >>> 16) + (oc - 16384);
		return s < 0 ? 0 : (s > 4095 ? 4095 : s);
	endfunction : target
	function automatic int effGain(int gc, int tv, int z, int k1, int k2);
		int dt;
		dt = tv - z;
		return (gc - 16384) + ((dt * k1) >>> 12)
			+ ((((dt * dt) >>> 16) * k2) >>> 12);
	endfunction : effGain
	task automatic tally_and_finish;
		if (errCount == 0 && cmpCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [31:0] x,
		input logic [31:0] y);
		cmpCount++;
		if (y !== x) begin
			errCount++;
			$display("MISMATCH %s expected %h seen %h", what, x, y);
		end
	endtask : check
	// Filter rounding may leave the last LSB off
	task automatic near(input string what, input int x, input logic [11:0] y);
		cmpCount++;
		if ($isunknown(y) || int'(y) < x - 1 || int'(y) > x + 1) begin
			errCount++;
			$display("MISMATCH %s expected %0d seen %h", what, x, y);
		end
	endtask : near
	task automatic waitReady;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			errCount++;
			tally_and_finish();
		end
	endtask : waitReady
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= 3'h2;
		waitReady();
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady();
		r = hrdata;
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] junk;
		ahb(1'b1, a, wd, junk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		ahb(1'b0, a, 32'h0, r);
	endtask : rd
	task automatic runCase(input int lp, input int n);
		wr(CTRL_OFS, 32'(lp * 4 + 1));
		wr(GAIN_OFS, 32'(g));
		wr(OFFS_OFS, 32'(o));
		hallLevel <= 16'(h);
		repeat (n) @(posedge clk);
		e = target(g, o, h);
	endtask : runCase

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hallLevel = 16'h0;
		tempLevel = 16'h0;
		slowMode = 1'b0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], d);
			check("reset value", rv[i], d);
		end
		for (int i = 0; i < 6; i++) begin
			wr(ra[i], 32'hffffffff);
			rd(ra[i], d);
			check("field width", rm[i], d);
			wr(ra[i], rv[i]);
		end
		wr(STAT_OFS, 32'hffffffff);
		wr(8'h24, 32'hffffffff);
		rd(8'h24, d);
		check("unmapped", 32'h0, d);
		for (int i = 0; i < 4; i++) begin
			wr(CTRL_OFS, {27'h0, LP_BYPASS, rc[i]});
			rd(STAT_OFS, d);
			check("span", {24'h0, sp[i]}, {24'h0, d[23:16]});
			check("adc range", {30'h0, rc[i]}, {30'h0, adcRange});
		end
		g = 32'h5000;
		for (int i = 0; i < 4; i++) begin
			t = $signed(rnd()) >>> 4;
			tz = $signed(rnd()) >>> 5;
			c1 = $signed(rnd()) >>> 3;
			c2 = rnd() & 16'h1fff;
			wr(TZERO_OFS, 32'(tz));
			wr(TCLIN_OFS, 32'(c1));
			wr(TCQUAD_OFS, 32'(c2));
			tempLevel <= 16'(t);
			repeat (4 * LPF_N + 40) @(posedge clk);
			rd(EGAIN_OFS, d);
			e = effGain(g, t, tz, c1, c2);
			check("eff gain", 32'(e), d);
		end
		wr(TCLIN_OFS, 32'h0);
		wr(TCQUAD_OFS, 32'h0);
		for (int i = 0; i < 8; i++) begin
			g = i < 5 ? cg[i] : 32'h4800 + (rnd() & 16'h1fff);
			o = i < 5 ? co[i] : 32'h4000 + (rnd() & 16'h0fff);
			h = i < 5 ? ch[i] : int'($signed(rnd()));
			slowMode <= (i >= 5);
			runCase(7, 400);
			check("dac code", 32'(e), {20'h0, dacHeld});
			rd(STAT_OFS, d);
			check("stat dac", 32'(e), {20'h0, d[11:0]});
		end
		g = 32'h5000;
		o = 32'h4800;
		for (int lp = 0; lp < 7; lp++) begin
			h = lp[0] ? 32'h2000 : -32'h4000;
			runCase(lp, ((LPF_N * 12) << (7 - lp)) + 400);
			near("filtered dac", e, dacHeld);
		end
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(CTRL_OFS, d);
		check("ctrl after reset", 32'h5, d);
		check("range after reset", {30'h0, RANGE_RST}, {30'h0, adcRange});
		tally_and_finish();
	end

	initial begin
		#800000;
		errCount++;
		tally_and_finish();
	end
endmodule : tb_hsc_conditioning

bind hsc_conditioning hsc_conditioning_chk #(.OUT_DIVN(OUT_DIVN))
	hsc_conditioning_chk_i (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .adcRange, .dacCode,
		.dacStrobe);
